// *** include/swtl_pkg.sv ***
// Shared constants, state codes and carriers of the single-wire token link.
// Assumes a 40 MHz reference clock; all cycle counts derive from it.
package swtl_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_PER_US = 1000 / CLK_PERIOD_NS;

  // Device-driven token shape, nominal figures in ns
  localparam int START_PULSE_WIDTH_NS = 6000;
  localparam int ZERO_GAP_HIGH_WIDTH_NS = 6000;
  localparam int ZERO_SECOND_LOW_WIDTH_NS = 6000;
  localparam int BIT_PERIOD_NS = 54000;
  localparam int DIRECTION_CHANGE_DELAY_NS = 60000;
  // Receive side figures in ns
  localparam int ACTIVE_GLITCH_WIDTH_NS = 45;
  localparam int SLEEP_LOW_GLITCH_WIDTH_NS = 2000;
  localparam int BIT_WINDOW_NS = 20000;
  // Long intervals in ms
  localparam int IO_IDLE_LIMIT_MS = 65;
  localparam int FORCED_SLEEP_INTERVAL_MS = 4000;
  localparam int BUS_IGNORE_WINDOW_MS = 25;

  localparam int START_CYC = START_PULSE_WIDTH_NS / CLK_PERIOD_NS;
  localparam int ZHI_CYC = ZERO_GAP_HIGH_WIDTH_NS / CLK_PERIOD_NS;
  localparam int ZLO_CYC = ZERO_SECOND_LOW_WIDTH_NS / CLK_PERIOD_NS;
  localparam int DEV_BIT_CYC = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TURN_CYC = DIRECTION_CHANGE_DELAY_NS / CLK_PERIOD_NS;
  localparam int ACTIVE_GLITCH_CYC =
    (ACTIVE_GLITCH_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_GLITCH_CYC =
    (SLEEP_LOW_GLITCH_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_WIN_CYC = BIT_WINDOW_NS / CLK_PERIOD_NS;
  localparam int IO_IDLE_CYC = IO_IDLE_LIMIT_MS * 1000 * CLK_PER_US;
  localparam int FORCED_SLEEP_CYC =
    FORCED_SLEEP_INTERVAL_MS * 1000 * CLK_PER_US;
  localparam int BUS_IGNORE_CYC = BUS_IGNORE_WINDOW_MS * 1000 * CLK_PER_US;

  localparam int FLAG_BITS = 8;
  localparam logic [7:0] FLAG_COMMAND = 8'h66;
  localparam logic [7:0] FLAG_TRANSMIT = 8'h99;
  localparam logic [7:0] FLAG_SLEEP = 8'hcc;

  typedef enum logic [7:0] {
    ST_SLEEP = 8'h01,
    ST_WAKE = 8'h02,
    ST_IDLE = 8'h04,
    ST_RXB = 8'h08,
    ST_BUSY = 8'h10,
    ST_TURN = 8'h20,
    ST_TX = 8'h40,
    ST_PAUSE = 8'h80
  } swtl_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } swtl_rx_beat_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } swtl_tx_beat_t;

endpackage

// *** rtl/swtl_glitch_filter.sv ***
// Synchroniser and short-pulse filter for the link wire input.
// Assumes the wire idles high; reads the raw pin from outside the clock.
module swtl_glitch_filter
  import swtl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Wire
  input wire logic pin_raw,
  output logic lvl
);

  logic sync_a;
  logic sync_b;
  logic [1:0] stable_cnt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else if (ce) begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  // A new level must persist for the whole filter width before it counts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lvl <= 1'b1;
      stable_cnt <= 2'h0;
    end else if (ce) begin
      if (sync_b == lvl) begin
        stable_cnt <= 2'h0;
      end else if (stable_cnt == 2'(ACTIVE_GLITCH_CYC - 1)) begin
        lvl <= sync_b;
        stable_cnt <= 2'h0;
      end else begin
        stable_cnt <= stable_cnt + 2'h1;
      end
    end
  end

  a_glitch_filter_width: assert property (
    @(posedge ref_clk) disable iff (rst)
    $changed(lvl) |-> $past(sync_b, 1) == lvl && $past(sync_b, 2) == lvl
  ) else $error("wire level changed on a pulse below the filter width");

endmodule

// *** rtl/swtl_link.sv ***
// Device end of the single-wire token link: wake, bit tokens, flags, blocks.
// Assumes the wire is open drain with a pull-up; command logic beside it
// consumes received block bytes and supplies response block bytes.
// How it works
// - A flag is exactly eight bit tokens
// - Blocks carry leading byte count and checksum
// - Packet bytes go to and from command logic
// - Device sends only zero and one tokens
// - Device pulses nominal 6 us, system 4.34 us
// - Wake-to-data beyond idle limit returns to sleep
// - Bit gaps reaching idle limit force sleep
// - Response starts 60 us after transmit flag
// - Active: pulses under 45 ns are ignored
// - Sleep: lows under 2 us never wake
// - Watchdog forces sleep fixed time after wake
// - Pause request ignores the wire for a window
// - Flags 66, 99, cc act; others ignored
// - Busy executing: wire transitions are ignored
module swtl_link
  import swtl_pkg::*;
#(
  parameter int unsigned IO_IDLE_LIMIT = IO_IDLE_CYC,
  parameter int unsigned FORCED_SLEEP_INTERVAL = FORCED_SLEEP_CYC,
  parameter int unsigned BUS_IGNORE_WINDOW = BUS_IGNORE_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Link wire, open drain
  input wire logic wire_in,
  output logic wire_out,
  output logic wire_oe,
  // Received block bytes
  output swtl_rx_beat_t rx_beat,
  output logic rx_valid,
  // Response block bytes
  input wire swtl_tx_beat_t tx_beat,
  input wire logic tx_valid,
  output logic tx_ready,
  // Command execution
  input wire logic exec_done,
  input wire logic bus_ignore_request,
  output logic busy,
  output logic awake
);

  swtl_state_t state;
  logic lvl;
  logic lvl_q;
  logic fall;
  logic [7:0] lo_cnt;
  logic win_on;
  logic [15:0] win_cnt;
  logic [1:0] falls;
  logic bit_done;
  logic bit_val;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic byte_done;
  logic [7:0] byte_val;
  logic [7:0] remain;
  logic byte_first;
  logic blk_last;
  logic [31:0] idle_cnt;
  logic [31:0] wdog_cnt;
  logic [31:0] tmr;
  logic idle_hit;
  logic wdog_hit;
  logic [15:0] txc;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_have;
  logic tx_last;
  logic tx_bit_end;
  logic listen;

  swtl_glitch_filter u_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .pin_raw(wire_in),
    .lvl(lvl)
  );

  assign fall = lvl_q & ~lvl;
  // Wire is watched only while awaiting tokens; busy and pause are deaf
  assign listen = (state == ST_IDLE) || (state == ST_RXB);
  assign bit_done = win_on && (win_cnt == 16'(BIT_WIN_CYC - 1));
  assign bit_val = (falls == 2'h1);
  assign byte_done = bit_done && (bit_cnt == 3'(FLAG_BITS - 1));
  assign byte_val = {bit_val, shreg[7:1]};
  assign blk_last = byte_first ? (byte_val <= 8'h01) : (remain == 8'h01);
  assign idle_hit = (idle_cnt == IO_IDLE_LIMIT - 1);
  assign wdog_hit = (wdog_cnt == FORCED_SLEEP_INTERVAL - 1);
  assign tx_bit_end = tx_have && (txc == 16'(DEV_BIT_CYC - 1));

  // Bit token decoder: counts falling edges inside a window from the start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lvl_q <= 1'b1;
      win_on <= 1'b0;
      win_cnt <= 16'h0;
      falls <= 2'h0;
      bit_cnt <= 3'h0;
      shreg <= 8'h0;
    end else if (ce) begin
      lvl_q <= lvl;
      if (!listen) begin
        win_on <= 1'b0;
        bit_cnt <= 3'h0;
      end else if (!win_on) begin
        if (fall) begin
          win_on <= 1'b1;
          win_cnt <= 16'h0;
          falls <= 2'h1;
        end
      end else begin
        win_cnt <= win_cnt + 16'h1;
        if (fall && falls != 2'h3) begin
          falls <= falls + 2'h1;
        end
        if (bit_done) begin
          win_on <= 1'b0;
          shreg <= byte_val;
          bit_cnt <= bit_cnt + 3'h1;
        end
      end
    end
  end

  // Idle, watchdog and shared interval timers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 32'h0;
      wdog_cnt <= 32'h0;
      tmr <= 32'h0;
    end else if (ce) begin
      if (fall || !(listen || state == ST_WAKE)) begin
        idle_cnt <= 32'h0;
      end else if (!idle_hit) begin
        idle_cnt <= idle_cnt + 32'h1;
      end
      if (state == ST_SLEEP) begin
        wdog_cnt <= 32'h0;
      end else if (!wdog_hit) begin
        wdog_cnt <= wdog_cnt + 32'h1;
      end
      if (state == ST_TURN || state == ST_PAUSE) begin
        tmr <= tmr + 32'h1;
      end else begin
        tmr <= 32'h0;
      end
    end
  end

  // Link state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_SLEEP;
      lo_cnt <= 8'h0;
    end else if (ce) begin
      lo_cnt <= (state == ST_SLEEP && !lvl) ? lo_cnt + 8'h1 : 8'h0;
      if (state != ST_SLEEP && wdog_hit) begin
        state <= ST_SLEEP;
      end else begin
        case (state)
          ST_SLEEP: begin
            if (lo_cnt == 8'(SLEEP_GLITCH_CYC - 1)) begin
              state <= ST_WAKE;
            end
          end
          ST_WAKE: begin
            if (idle_hit) begin
              state <= ST_SLEEP;
            end else if (lvl) begin
              state <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            if (idle_hit) begin
              state <= ST_SLEEP;
            end else if (bus_ignore_request) begin
              state <= ST_PAUSE;
            end else if (byte_done) begin
              if (byte_val == FLAG_COMMAND) begin
                state <= ST_RXB;
              end else if (byte_val == FLAG_TRANSMIT) begin
                state <= ST_TURN;
              end else if (byte_val == FLAG_SLEEP) begin
                state <= ST_SLEEP;
              end
            end
          end
          ST_RXB: begin
            if (idle_hit) begin
              state <= ST_SLEEP;
            end else if (byte_done && blk_last) begin
              state <= ST_BUSY;
            end
          end
          ST_BUSY: begin
            if (bus_ignore_request) begin
              state <= ST_PAUSE;
            end else if (exec_done) begin
              state <= ST_IDLE;
            end
          end
          ST_TURN: begin
            if (tmr == 32'(TURN_CYC - 1)) begin
              state <= ST_TX;
            end
          end
          ST_TX: begin
            if (tx_bit_end && tx_bit == 3'(FLAG_BITS - 1) && tx_last) begin
              state <= ST_IDLE;
            end
          end
          ST_PAUSE: begin
            if (tmr == BUS_IGNORE_WINDOW - 1) begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_SLEEP;
          end
        endcase
      end
    end
  end

  // Received block bytes, count byte first, length taken from it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_beat <= '0;
      rx_valid <= 1'b0;
      remain <= 8'h0;
      byte_first <= 1'b1;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (state != ST_RXB) begin
        byte_first <= 1'b1;
      end else if (byte_done) begin
        rx_valid <= 1'b1;
        rx_beat.data <= byte_val;
        rx_beat.first <= byte_first;
        rx_beat.last <= blk_last;
        byte_first <= 1'b0;
        remain <= byte_first ? byte_val - 8'h1 : remain - 8'h1;
      end
    end
  end

  // Response bytes go out LSB first, one token per bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txc <= 16'h0;
      tx_bit <= 3'h0;
      tx_sh <= 8'h0;
      tx_have <= 1'b0;
      tx_last <= 1'b0;
      tx_ready <= 1'b0;
      wire_oe <= 1'b0;
    end else if (ce) begin
      tx_ready <= 1'b0;
      if (state != ST_TX) begin
        tx_have <= 1'b0;
        wire_oe <= 1'b0;
      end else if (!tx_have) begin
        wire_oe <= 1'b0;
        if (tx_ready && tx_valid) begin
          tx_sh <= tx_beat.data;
          tx_last <= tx_beat.last;
          tx_have <= 1'b1;
          txc <= 16'h0;
          tx_bit <= 3'h0;
        end else begin
          tx_ready <= 1'b1;
        end
      end else begin
        // One holds a single start low; zero adds a second low
        wire_oe <= (txc < 16'(START_CYC)) || (!tx_sh[0] &&
          txc >= 16'(START_CYC + ZHI_CYC) &&
          txc < 16'(START_CYC + ZHI_CYC + ZLO_CYC));
        if (tx_bit_end) begin
          txc <= 16'h0;
          tx_sh <= {1'b0, tx_sh[7:1]};
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == 3'(FLAG_BITS - 1)) begin
            tx_have <= 1'b0;
          end
        end else begin
          txc <= txc + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wire_out <= 1'b0;
      busy <= 1'b0;
      awake <= 1'b0;
    end else if (ce) begin
      wire_out <= 1'b0;
      busy <= (state == ST_BUSY);
      awake <= (state != ST_SLEEP);
    end
  end

  // Helper: length of the current driven low
  logic [15:0] oe_len;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oe_len <= 16'h0;
    end else if (ce) begin
      oe_len <= wire_oe ? oe_len + 16'h1 : 16'h0;
    end
  end

  sequence s_turn_done;
    state == ST_TURN ##1 state == ST_TX;
  endsequence

  a_drive_only_tx: assert property (
    @(posedge ref_clk) disable iff (rst)
    wire_oe |-> $past(state) == ST_TX
  ) else $error("wire driven outside response transmit");

  // Start low and the second low of a zero share one width
  a_low_pulse_len: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && $fell(wire_oe) |-> oe_len == 16'(START_CYC)
  ) else $error("device low pulse has wrong width");

  a_turnaround_wait: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_turn_done |-> $past(tmr) == 32'(TURN_CYC - 1) && !wire_oe
  ) else $error("response began at wrong turn-around time");

  a_flag_eight_bits: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(state) == ST_IDLE && state == ST_RXB |-> $past(bit_cnt) == 3'h7
  ) else $error("flag accepted after wrong bit count");

  a_flag_reserved: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && state == ST_IDLE && byte_done && !idle_hit && !wdog_hit &&
      !bus_ignore_request && byte_val != FLAG_COMMAND &&
      byte_val != FLAG_TRANSMIT && byte_val != FLAG_SLEEP
      |=> state == ST_IDLE
  ) else $error("reserved flag value changed state");

  a_busy_deaf: assert property (
    @(posedge ref_clk) disable iff (rst)
    state == ST_BUSY |-> !listen && !win_on
  ) else $error("wire watched while busy");

  a_sleep_glitch: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(state) == ST_SLEEP && state == ST_WAKE
      |-> $past(lo_cnt) == 8'(SLEEP_GLITCH_CYC - 1)
  ) else $error("woke on a low shorter than the sleep filter");

  a_watchdog_sleep: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wdog_hit && state != ST_SLEEP |=> state == ST_SLEEP
  ) else $error("watchdog did not force sleep");

  a_idle_timeout: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && idle_hit && listen |=> state == ST_SLEEP
  ) else $error("idle limit did not force sleep");

  a_pause_window: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(state) == ST_PAUSE && state == ST_IDLE
      |-> $past(tmr) == BUS_IGNORE_WINDOW - 1
  ) else $error("pause window ended at wrong time");

endmodule

// *** bench/swtl_host_model.sv ***
// System master model: wake, system bit tokens, response bit decoding.
// Assumes the bench resolves the open-drain wire with a pull-up.
module swtl_host_model #(
  parameter int WAKE_LOW = 2400,
  parameter int WAKE_GAP = 400
) (
  // Clock
  input wire logic ref_clk,
  // Wire
  input wire logic wire_lvl,
  output logic host_low
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PULSE = 174;
  // One link bit per UART byte time at the system end
  localparam int BIT_CYC = 1480;

  initial host_low = 1'b0;

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic drive(input logic low, input int n);
    host_low = low;
    step(n);
  endtask

  // Wake gap is shortened in step with the shortened idle limit
  task automatic wake();
    drive(1'b1, WAKE_LOW);
    drive(1'b0, WAKE_GAP);
  endtask

  task automatic glitch();
    drive(1'b1, 1);
    drive(1'b0, 20);
  endtask

  task automatic send_bit(input logic b, input logic hg);
    if (b && hg) begin
      drive(1'b1, 80);
      drive(1'b0, 1);
      drive(1'b1, PULSE - 81);
      drive(1'b0, BIT_CYC - PULSE);
    end else if (b) begin
      drive(1'b1, PULSE);
      drive(1'b0, BIT_CYC - PULSE);
    end else begin
      drive(1'b1, PULSE);
      drive(1'b0, PULSE);
      drive(1'b1, PULSE);
      drive(1'b0, BIT_CYC - 3 * PULSE);
    end
  endtask

  task automatic send_byte(input logic [7:0] v, input logic hg);
    for (int i = 0; i < 8; i++) begin
      send_bit(v[i], hg && (i == 0));
    end
  endtask

  // Turn is counted from the end of the flag to the first device low
  task automatic recv_byte(output logic [7:0] v, output int wmin,
                           output int wmax, output int turn);
    int n;
    int falls;
    int run;
    logic prev;
    v = '0;
    wmin = 1000000;
    wmax = 0;
    turn = 0;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (wire_lvl !== 1'b0 && n < 4000) begin
        step(1);
        n++;
      end
      if (i == 0) turn = n;
      falls = 0;
      run = 0;
      prev = 1'b1;
      for (int k = 0; k < 1200; k++) begin
        if (prev && wire_lvl === 1'b0) falls++;
        if (wire_lvl === 1'b0) run++;
        else if (run > 0) begin
          wmin = (run < wmin) ? run : wmin;
          wmax = (run > wmax) ? run : wmax;
          run = 0;
        end
        prev = (wire_lvl !== 1'b0);
        step(1);
      end
      v[i] = (falls == 1);
    end
  endtask
endmodule

// *** bench/swtl_link_tb.sv ***
// Self-checking bench of the device end of the single-wire token link.
// Assumes shortened idle, watchdog and pause counts; the system side is
// played by swtl_host_model over an open-drain wire with pull-up.
module swtl_link_tb;
  import swtl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // Shortened so the run stays near 140k cycles
  localparam int IDLE_LIM = 4000;
  localparam int WDOG = 70000;
  localparam int PAUSE_WIN = 500;

  logic ref_clk, rst, ce, wire_out, wire_oe, rx_valid, tx_valid, tx_ready;
  logic exec_done, bus_ignore_request, busy, awake;
  logic host_low, wire_lvl, tx_phase;
  swtl_rx_beat_t rx_beat;
  swtl_tx_beat_t tx_beat;
  swtl_rx_beat_t exp_rx[$];
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t_wake, wmin, wmax, tturn;
  logic [31:0] seed = 32'h9e038cb3;
  logic [7:0] rv, td;

  assign wire_lvl = !host_low && !(wire_oe && !wire_out);

  swtl_link #(
    .IO_IDLE_LIMIT(IDLE_LIM),
    .FORCED_SLEEP_INTERVAL(WDOG),
    .BUS_IGNORE_WINDOW(PAUSE_WIN)
  ) dut_u (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .wire_in(wire_lvl), .wire_out(wire_out), .wire_oe(wire_oe),
    .rx_beat(rx_beat), .rx_valid(rx_valid),
    .tx_beat(tx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .exec_done(exec_done), .bus_ignore_request(bus_ignore_request),
    .busy(busy), .awake(awake)
  );

  swtl_host_model host_u (
    .ref_clk(ref_clk), .wire_lvl(wire_lvl), .host_low(host_low)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got,
               exp);
    end
  endtask

  task automatic end_sim();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic blk_byte(input logic [7:0] d, input logic f, input logic l);
    exp_rx.push_back(swtl_rx_beat_t'({d, f, l}));
    host_u.send_byte(d, 1'b0);
  endtask

  task automatic wait_until(input int t);
    while (cyc < t) host_u.step(1);
  endtask

  // Reference model: every block byte is judged here, and every wire drive outside the response phase
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_rx.size() == 0) chk(1, 0, "unexpected rx byte");
      else chk(rx_beat, exp_rx.pop_front(), "rx beat");
    end
    if (rst === 1'b0 && tx_phase === 1'b0) chk(wire_oe, 0, "stray drive");
    if (rst === 1'b0) chk(wire_out, 0, "open-drain data level");
  end

  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      #2;
      tx_valid = 1'b0;
    end
  end

  initial begin
    repeat (200000) @(posedge ref_clk);
    failures++;
    $display("Error at %0t: run did not finish", $time);
    end_sim();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tx_valid = 1'b0;
    tx_beat = '0;
    exec_done = 1'b0;
    bus_ignore_request = 1'b0;
    tx_phase = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    chk(awake, 1'b0, "awake after reset");
    host_u.drive(1'b1, 40);
    host_u.drive(1'b0, 200);
    chk(awake, 1'b0, "short low woke");
    host_u.wake();
    chk(awake, 1'b1, "wake");
    rv = rnd8();
    if (rv == FLAG_COMMAND || rv == FLAG_TRANSMIT || rv == FLAG_SLEEP) begin
      rv ^= 8'h01;
    end
    host_u.send_byte(rv, 1'b0);
    chk(busy, 1'b0, "reserved flag");
    host_u.send_byte(FLAG_COMMAND, 1'b0);
    blk_byte(8'h02, 1'b1, 1'b0);
    blk_byte(rnd8(), 1'b0, 1'b1);
    chk(busy, 1'b1, "busy after block");
    host_u.send_bit(1'b1, 1'b0);
    chk(busy, 1'b1, "busy held");
    exec_done = 1'b1;
    host_u.step(1);
    exec_done = 1'b0;
    host_u.step(3);
    chk(busy, 1'b0, "exec done");
    bus_ignore_request = 1'b1;
    host_u.step(1);
    bus_ignore_request = 1'b0;
    host_u.step(1);
    // A bit taken here would turn the sleep flag into a transmit flag
    host_u.send_bit(1'b1, 1'b0);
    host_u.send_byte(FLAG_SLEEP, 1'b0);
    chk(awake, 1'b0, "sleep after pause");
    host_u.wake();
    host_u.step(200);
    chk(awake, 1'b1, "awake before limit");
    host_u.step(IDLE_LIM);
    chk(awake, 1'b0, "idle limit");
    // A long low while the clock enable is low must not wake the link
    ce = 1'b0;
    host_u.drive(1'b1, 100 + rnd8());
    host_u.drive(1'b0, 2);
    chk(awake, 1'b0, "woke while clock enable low");
    ce = 1'b1;
    host_u.step(4);
    chk(awake, 1'b0, "woke after clock enable returned");
    t_wake = cyc;
    host_u.wake();
    repeat (3) host_u.glitch();
    td = rnd8();
    tx_beat = {td, 1'b1};
    tx_valid = 1'b1;
    tx_phase = 1'b1;
    host_u.send_byte(FLAG_TRANSMIT, 1'b1);
    host_u.recv_byte(rv, wmin, wmax, tturn);
    tx_phase = 1'b0;
    chk(rv, td, "response byte");
    chk(tturn >= 1120 && tturn <= 3800, 1'b1, "turn-around");
    chk(wmin >= 184 && wmax <= 344, 1'b1, "device pulse width");
    chk(tx_valid, 1'b0, "response byte taken");
    host_u.step(1600);
    host_u.send_byte(FLAG_COMMAND, 1'b0);
    blk_byte(8'h01, 1'b1, 1'b1);
    chk(busy, 1'b1, "busy after short block");
    wait_until(t_wake + WDOG - 300);
    chk(awake, 1'b1, "early forced sleep");
    wait_until(t_wake + WDOG + 300);
    chk(awake, 1'b0, "watchdog sleep");
    chk(exp_rx.size(), 0, "missing rx bytes");
    end_sim();
  end
endmodule
